// >>> rtl/usb_endpoint_status_control.sv
// endpoint and bus-state control and status registers of a low-speed usb serial engine, apb slave
//
// Notes on behaviour
// - access flag per endpoint set when host accesses it; read-only, resets to zero
// - direction bits 1..3 select IN (1) or OUT (0); reset all IN
// - low on toggle-reset bit forces endpoint 1..3 data toggles to DATA0
// - enable bits gate endpoints; endpoint 0 never disabled; reset all enabled
// - line-state bit 0 set on EOP, sticky until firmware clears it
// - line-state bit 1 set on J, bit 2 on K, sticky
// - line-state bit 3 set on SE0 noise, bit 4 on SE1 noise, sticky
// - deferred-address bit set: load address after successful IN, then clear bit
// - deferred-address bit clear: address register write takes effect at once
// - engine status bit 1 set on FIFO0 access error, cleared by firmware
// - nak-mute bit set: endpoint 0 NAK accesses raise no usb interrupt
// - fifo command and status register cleared by usb bus reset
// - endpoint access sets its interrupt flag and raises usb interrupt
`timescale 1ns/1ps
`default_nettype none
`include "usb_ep_params.svh"

module usb_endpoint_status_control
    import usb_ep_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              REF_CLK,
    input  wire logic              NRST,
    // apb slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    input  wire logic [3:0]        PSTRB,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // serial engine side
    input  wire sie_ev_s           SIE_EV,
    output ep_cfg_s                EP_CFG,
    output logic      [6:0]        DEV_ADDR,
    output logic                   REMOTE_WAKEUP,
    output logic      [4:0]        FIFO_CMD,
    output logic                   ACCESS_EVENT,
    output logic                   IRQ
);

    ////////////////////////////////////////////////////////////////////////////////
    // register storage

    logic [4:0] line_flags;
    logic [3:1] dir_in;
    logic       toggle_rst_n;
    logic [3:0] halt;
    logic [3:0] access;
    logic       adr_defer;
    logic       fifo0_err;
    logic       nak_mute;
    logic [3:0] ep_enable;
    logic [3:0] endpoint_interrupt_flag;
    logic [7:0] device_address_wakeup_reg;
    logic [6:0] dev_addr;
    logic [4:0] fifo_cmd;
    logic [3:1] data_toggle;
    logic [7:0] irq_status;
    logic [7:0] irq_enable;
    logic [7:0] rd_byte;
    logic       rd_err;

    // reset values cut to each register's width; the header keeps them as bytes
    localparam logic [4:0] rst_line  = 5'(`RST_LINE_STATE & `MASK_LINE_STATE);
    localparam logic [2:0] rst_dir   = 3'(`RST_DIR_TOGGLE >> 1);
    localparam logic       rst_tog_n = 1'(`RST_DIR_TOGGLE >> `BIT_TOGGLE_RST);
    localparam logic [3:0] rst_halt  = 4'(`RST_HALT & `MASK_NIBBLE);
    localparam logic [3:0] rst_en    = 4'(`RST_EP_ENABLE & `MASK_NIBBLE);
    localparam logic [3:0] rst_acc   = 4'(`RST_ACCESS);
    localparam logic [3:0] rst_epint = 4'(`RST_EP_INT_FLAG);
    localparam logic [4:0] rst_fifo  = 5'(`RST_FIFO_CMD & `MASK_FIFO_CMD);
    localparam logic [6:0] rst_addr  = 7'(`RST_DEV_ADDR);
    localparam logic [7:0] rst_eng   = `RST_ENGINE_STATUS;

    ////////////////////////////////////////////////////////////////////////////////
    // apb decode

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        byte_addr = ADDR_W'({idx, 2'b00});
    endfunction

    wire setup_ph  = PSEL & ~PENABLE;
    wire wr_acc    = PSEL & PENABLE & PWRITE;
    wire lane0     = PSTRB[0];                  // only the low byte holds data
    wire [7:0] wd  = PWDATA[7:0];

    wire sel_line  = PADDR == byte_addr(`IDX_LINE_STATE);
    wire sel_dir   = PADDR == byte_addr(`IDX_DIR_TOGGLE);
    wire sel_halt  = PADDR == byte_addr(`IDX_HALT);
    wire sel_acc   = PADDR == byte_addr(`IDX_ACCESS);
    wire sel_eng   = PADDR == byte_addr(`IDX_ENGINE_STATUS);
    wire sel_en    = PADDR == byte_addr(`IDX_EP_ENABLE);
    wire sel_epint = PADDR == byte_addr(`IDX_EP_INT_FLAG);
    wire sel_addr  = PADDR == byte_addr(`IDX_DEV_ADDR);
    wire sel_fifo  = PADDR == byte_addr(`IDX_FIFO_CMD);
    wire sel_ista  = PADDR == byte_addr(`IDX_IRQ_STATUS);
    wire sel_iclr  = PADDR == byte_addr(`IDX_IRQ_CLEAR);
    wire sel_ien   = PADDR == byte_addr(`IDX_IRQ_ENABLE);

    wire mapped = sel_line | sel_dir | sel_halt | sel_acc | sel_eng | sel_en
                | sel_epint | sel_addr | sel_fifo | sel_ista | sel_iclr | sel_ien;

    // per-register write strobes, only in the completing access cycle
    wire wr_ok     = wr_acc & lane0;
    wire wr_line   = wr_ok & sel_line;
    wire wr_dir    = wr_ok & sel_dir;
    wire wr_halt   = wr_ok & sel_halt;
    wire wr_eng    = wr_ok & sel_eng;
    wire wr_en     = wr_ok & sel_en;
    wire wr_epint  = wr_ok & sel_epint;
    wire wr_addr   = wr_ok & sel_addr;
    wire wr_fifo   = wr_ok & sel_fifo;
    wire wr_iclr   = wr_ok & sel_iclr;
    wire wr_ien    = wr_ok & sel_ien;

    // read-back mux; reserved bits fall out as zero
    wire [7:0] line_rd = {3'b000, line_flags};
    wire [7:0] dir_rd  = {4'h0, dir_in, toggle_rst_n};
    wire [7:0] eng_rd  = {nak_mute, 5'b00000, fifo0_err, adr_defer};
    wire [7:0] rd_mux  = ({8{sel_line}}  & line_rd)
                       | ({8{sel_dir}}   & dir_rd)
                       | ({8{sel_halt}}  & {4'h0, halt})
                       | ({8{sel_acc}}   & {4'h0, access})
                       | ({8{sel_eng}}   & eng_rd)
                       | ({8{sel_en}}    & {4'h0, ep_enable})
                       | ({8{sel_epint}} & {4'h0, endpoint_interrupt_flag})
                       | ({8{sel_addr}}  & device_address_wakeup_reg)
                       | ({8{sel_fifo}}  & {3'b000, fifo_cmd})
                       | ({8{sel_ista}}  & irq_status)
                       | ({8{sel_ien}}   & irq_enable);

    // read data and error are captured in the setup cycle so they come from flops
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            rd_byte <= 8'h00;
            rd_err  <= 1'b0;
        end else if (setup_ph) begin
            rd_byte <= PWRITE ? 8'h00 : rd_mux;
            rd_err  <= ~mapped;
        end
    end

    // zero wait states; every access ends in its first access cycle
    assign PREADY  = 1'b1;
    assign PRDATA  = {24'h000000, rd_byte};
    assign PSLVERR = PSEL & PENABLE & rd_err;

    ////////////////////////////////////////////////////////////////////////////////
    // endpoint gating and access events

    // endpoint 0 cannot be switched off
    wire [3:0] ep_live = {ep_enable[3:1], 1'b1};

    // a nak on endpoint 0 is muted when the mute bit is set
    wire ep0_muted = nak_mute & SIE_EV.ep0_nak;
    wire [3:0] ep_hit = SIE_EV.ep_access & ep_live;
    wire [3:0] ep_int_set = ep_hit & {3'b111, ~ep0_muted};

    ////////////////////////////////////////////////////////////////////////////////
    // per-endpoint flags and data toggles

    // one copy of the flag logic per endpoint
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_ep
            // access flag is sticky and read-only
            always_ff @(posedge REF_CLK or negedge NRST) begin
                if (!NRST) begin
                    access[gi] <= rst_acc[gi];
                end else if (ep_hit[gi]) begin
                    access[gi] <= 1'b1;
                end
            end

            // interrupt flag: writing 0 clears, a same-cycle access wins
            always_ff @(posedge REF_CLK or negedge NRST) begin
                if (!NRST) begin
                    endpoint_interrupt_flag[gi] <= rst_epint[gi];
                end else if (ep_int_set[gi]) begin
                    endpoint_interrupt_flag[gi] <= 1'b1;
                end else if (wr_epint) begin
                    endpoint_interrupt_flag[gi] <= endpoint_interrupt_flag[gi] & wd[gi];
                end
            end

            if (gi > 0) begin : g_tog
                // toggle held at DATA0 while the reset bit sits low
                always_ff @(posedge REF_CLK or negedge NRST) begin
                    if (!NRST) begin
                        data_toggle[gi] <= 1'b0;
                    end else if (!toggle_rst_n) begin
                        data_toggle[gi] <= 1'b0;
                    end else if (SIE_EV.toggle_flip[gi] & ep_live[gi]) begin
                        data_toggle[gi] <= ~data_toggle[gi];
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // line-state flags

    // sticky detections; firmware clears by writing 0, a new detection wins
    wire [4:0] line_set = SIE_EV.line;
    wire [4:0] line_keep = wr_line ? (line_flags & wd[4:0]) : line_flags;

    // or-ing the set last means no detection is lost to a clear
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            line_flags <= rst_line;
        end else begin
            line_flags <= line_keep | line_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // direction, halt and enable registers

    // direction bits and the active-low toggle reset share one word
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            dir_in       <= rst_dir;
            toggle_rst_n <= rst_tog_n;
        end else if (wr_dir) begin
            dir_in       <= wd[3:1];
            toggle_rst_n <= wd[`BIT_TOGGLE_RST];
        end
    end

    // halt flags are firmware-owned and passed straight to the engine
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            halt <= rst_halt;
        end else if (wr_halt) begin
            halt <= wd[3:0];
        end
    end

    // bit 0 is stored and read back but never gates endpoint 0
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            ep_enable <= rst_en;
        end else if (wr_en) begin
            ep_enable <= wd[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // engine status: deferred address, fifo0 error, nak mute

    // engine clears the deferred bit once the pending address is taken
    wire addr_commit = adr_defer & SIE_EV.in_done;

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            adr_defer <= rst_eng[`BIT_ADR_DEFER];
            nak_mute  <= rst_eng[`BIT_NAK_MUTE];
        end else if (wr_eng) begin
            adr_defer <= wd[`BIT_ADR_DEFER];
            nak_mute  <= wd[`BIT_NAK_MUTE];
        end else if (addr_commit) begin
            adr_defer <= 1'b0;
        end
    end

    // error flag: set wins over a firmware clear in the same cycle
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            fifo0_err <= rst_eng[`BIT_FIFO0_ERR];
        end else if (SIE_EV.fifo0_err) begin
            fifo0_err <= 1'b1;
        end else if (wr_eng) begin
            fifo0_err <= fifo0_err & wd[`BIT_FIFO0_ERR];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // device address

    // firmware copy of address and wake bit, loaded on every write
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            device_address_wakeup_reg <= `RST_DEV_ADDR;
        end else if (wr_addr) begin
            device_address_wakeup_reg <= wd;
        end
    end

    // immediate load when not deferred, else on the completed IN
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            dev_addr <= rst_addr;
        end else if (wr_addr & ~adr_defer) begin
            dev_addr <= wd[6:0];
        end else if (addr_commit) begin
            dev_addr <= device_address_wakeup_reg[6:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // fifo command and status

    // bus reset outranks a firmware write in the same cycle
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            fifo_cmd <= rst_fifo;
        end else if (SIE_EV.bus_reset) begin
            fifo_cmd <= 5'h00;
        end else if (wr_fifo) begin
            fifo_cmd <= wd[4:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt status, clear and enable

    // one status bit per event class
    wire [7:0] irq_set;
    assign irq_set[`IRQ_LINE_LSB +: 5] = line_set;
    assign irq_set[`IRQ_FIFO0_ERR]     = SIE_EV.fifo0_err;
    assign irq_set[`IRQ_EP_ACCESS]     = |ep_int_set;
    assign irq_set[`IRQ_BUS_RESET]     = SIE_EV.bus_reset;

    // write-one-to-clear; an event in the clearing cycle survives
    wire [7:0] irq_clr = wr_iclr ? wd : 8'h00;

    // sticky status; clear applied before the new set
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            irq_status <= `RST_IRQ;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
        end
    end

    // enable mask, same layout as the status word
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            irq_enable <= `RST_IRQ;
        end else if (wr_ien) begin
            irq_enable <= wd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    // configuration and address straight from their flops
    assign EP_CFG.enable      = ep_live;
    assign EP_CFG.halt        = halt;
    assign EP_CFG.dir_in      = dir_in;
    assign EP_CFG.data_toggle = data_toggle;
    assign DEV_ADDR           = dev_addr;
    assign REMOTE_WAKEUP      = device_address_wakeup_reg[`BIT_REMOTE_WAKE];
    assign FIFO_CMD           = fifo_cmd;
    // usb interrupt stays up while any endpoint flag is pending
    assign ACCESS_EVENT       = |endpoint_interrupt_flag;
    assign IRQ                = |(irq_status & irq_enable);

endmodule

`default_nettype wire

// >>> rtl/usb_ep_params.svh
// register indices, byte addressing, field positions and reset values of the endpoint status block
`ifndef USB_EP_PARAMS_SVH
`define USB_EP_PARAMS_SVH

// register indices; byte address is four times the index
`define IDX_LINE_STATE     8'h40
`define IDX_DIR_TOGGLE     8'h41
`define IDX_HALT           8'h43
`define IDX_ACCESS         8'h44
`define IDX_ENGINE_STATUS  8'h45
`define IDX_EP_ENABLE      8'h47
`define IDX_EP_INT_FLAG    8'h48
`define IDX_DEV_ADDR       8'h49
`define IDX_FIFO_CMD       8'h4a
`define IDX_IRQ_STATUS     8'h4c
`define IDX_IRQ_CLEAR      8'h4d
`define IDX_IRQ_ENABLE     8'h4e

// reset values
`define RST_LINE_STATE     8'h00
`define RST_DIR_TOGGLE     8'h0e
`define RST_HALT           8'h0e
`define RST_ACCESS         8'h00
`define RST_ENGINE_STATUS  8'h00
`define RST_EP_ENABLE      8'h0f
`define RST_EP_INT_FLAG    8'h00
`define RST_DEV_ADDR       8'h00
`define RST_FIFO_CMD       8'h00
`define RST_IRQ            8'h00

// writable bit masks
`define MASK_LINE_STATE    8'h1f
`define MASK_NIBBLE        8'h0f
`define MASK_ENGINE_STATUS 8'h83
`define MASK_FIFO_CMD      8'h1f

// field positions
`define BIT_TOGGLE_RST     0
`define BIT_ADR_DEFER      0
`define BIT_FIFO0_ERR      1
`define BIT_NAK_MUTE       7
`define BIT_REMOTE_WAKE    7

// interrupt status positions
`define IRQ_LINE_LSB       0
`define IRQ_FIFO0_ERR      5
`define IRQ_EP_ACCESS      6
`define IRQ_BUS_RESET      7

`endif

// >>> rtl/usb_ep_pkg.sv
// types shared by the endpoint status and control block
`default_nettype none
package usb_ep_pkg;

    // line-state detections from the serial engine, one-cycle pulses
    typedef struct packed {
        logic se1;
        logic se0;
        logic k_state;
        logic j_state;
        logic eop;
    } line_ev_s;

    // event pulses from the serial engine on the same clock
    typedef struct packed {
        logic       bus_reset;
        logic       in_done;
        logic       fifo0_err;
        logic       ep0_nak;
        logic [3:0] ep_access;
        logic [3:1] toggle_flip;
        line_ev_s   line;
    } sie_ev_s;

    // endpoint configuration handed to the serial engine
    typedef struct packed {
        logic [3:0] enable;
        logic [3:0] halt;
        logic [3:1] dir_in;
        logic [3:1] data_toggle;
    } ep_cfg_s;

endpackage

`default_nettype wire

// >>> sim/usb_endpoint_status_control_test.sv
// self-checking bench: apb register tests and engine events
`timescale 1ns/1ps
`default_nettype none

module usb_endpoint_status_control_test
    import usb_ep_pkg::*;
;
    logic        REF_CLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
    logic        REMOTE_WAKEUP, ACCESS_EVENT, IRQ;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [3:0]  PSTRB;
    logic [6:0]  DEV_ADDR;
    logic [4:0]  FIFO_CMD;
    sie_ev_s     SIE_EV;
    ep_cfg_s     EP_CFG;
    int          error_cnt = 0;
    int          tests_run = 0;
    logic [7:0]  ridx [6] = '{8'h40, 8'h41, 8'h43, 8'h44, 8'h45, 8'h47};
    logic [7:0]  rexp [6] = '{8'h00, 8'h0e, 8'h0e, 8'h00, 8'h00, 8'h0f};

    usb_endpoint_status_control #(.ADDR_W(12)) usb_endpoint_status_control_i (
        .REF_CLK(REF_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .SIE_EV(SIE_EV), .EP_CFG(EP_CFG), .DEV_ADDR(DEV_ADDR),
        .REMOTE_WAKEUP(REMOTE_WAKEUP), .FIFO_CMD(FIFO_CMD), .ACCESS_EVENT(ACCESS_EVENT), .IRQ(IRQ)
    );
    usb_sie_model usb_sie_model_i (.REF_CLK(REF_CLK), .SIE_EV(SIE_EV));

    // 100 MHz
    initial begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end
    ////////////////////////////////////////
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen high at an edge
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge REF_CLK);
        PSEL   <= 1'b1;
        PWRITE <= w;
        PADDR  <= {2'h0, idx, 2'h0};
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge REF_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            results();
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
        #1;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask
    task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask
    // irq may come from a flop behind status and enable, so allow it to settle
    task automatic irq_is(input logic exp);
        repeat (2) @(posedge REF_CLK);
        #1;
        chk(32'(IRQ), 32'(exp));
    endtask
    initial begin
        repeat (20000) @(posedge REF_CLK);
        error_cnt++;
        results();
    end
    ////////////////////////////////////////
    initial begin
        NRST    = 1'b0;
        PSEL    = 1'b0;
        PENABLE = 1'b0;
        PWRITE  = 1'b0;
        PADDR   = '0;
        PWDATA  = '0;
        PSTRB   = 4'h1;
        repeat (20) @(posedge REF_CLK);
        NRST <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rc(ridx[i], 32'(rexp[i]));
        end
        chk(32'(EP_CFG), 32'({4'hf, 4'he, 3'h7, 3'h0}));
        // hole in the map, masked strobe, reserved bits
        wr(8'h42, 32'hff);
        chk(32'(err), 32'h1);
        @(posedge REF_CLK) PSTRB <= 4'he;
        wr(8'h43, 32'h01);
        @(posedge REF_CLK) PSTRB <= 4'h1;
        rc(8'h43, 32'h0e);
        wr(8'h43, 32'hf1);
        rc(8'h43, 32'h01);
        chk(32'(EP_CFG.halt), 32'h1);
        chk(32'(err), 32'h0);
        // direction and toggle reset held low for fifteen cycles
        wr(8'h41, 32'h0b);
        chk(32'(EP_CFG.dir_in), 32'h5);
        usb_sie_model_i.pulse(16'h00e0, 2);
        chk(32'(EP_CFG.data_toggle), 32'h7);
        wr(8'h41, 32'h0a);
        usb_sie_model_i.pulse(16'h00e0, 10);
        chk(32'(EP_CFG.data_toggle), 32'h0);
        wr(8'h41, 32'h0b);
        // endpoints 1..3 off, then access all four
        wr(8'h47, 32'hf0);
        rc(8'h47, 32'h00);
        chk(32'(EP_CFG.enable), 32'h1);
        usb_sie_model_i.pulse(16'h0f00, 1);
        wr(8'h44, 32'hff);
        rc(8'h44, 32'h01);
        chk(32'(ACCESS_EVENT), 32'h1);
        wr(8'h4e, 32'h40);
        irq_is(1'b1);
        wr(8'h4d, 32'hff);
        wr(8'h48, 32'h00);
        irq_is(1'b0);
        // nak on endpoint 0 muted, real transfer on endpoint 3 still counts
        wr(8'h47, 32'h0f);
        wr(8'h45, 32'h80);
        usb_sie_model_i.pulse(16'h1100, 0);
        rc(8'h48, 32'h00);
        usb_sie_model_i.pulse(16'h0800, 3);
        rc(8'h44, 32'h09);
        rc(8'h48, 32'h08);
        wr(8'h45, 32'h00);
        wr(8'h48, 32'h00);
        usb_sie_model_i.pulse(16'h1100, 0);
        rc(8'h48, 32'h01);
        // line-state events one by one, each sticky
        wr(8'h4d, 32'hff);
        wr(8'h4e, 32'h1f);
        for (int i = 0; i < 5; i++) begin
            usb_sie_model_i.pulse(16'h1 << i, i);
            chk(32'(IRQ), 32'h1);
            rc(8'h40, (32'h2 << i) - 32'h1);
        end
        wr(8'h40, 32'h1a);
        rc(8'h40, 32'h1a);
        wr(8'h4d, 32'hff);
        wr(8'h4e, 32'h00);
        usb_sie_model_i.pulse(16'h0001, 0);
        irq_is(1'b0);
        wr(8'h4e, 32'h01);
        irq_is(1'b1);
        wr(8'h4d, 32'h01);
        irq_is(1'b0);
        // fifo0 error flag, cleared by writing zero
        usb_sie_model_i.pulse(16'h2000, 1);
        rc(8'h45, 32'h02);
        wr(8'h45, 32'h00);
        rc(8'h45, 32'h00);
        // direct then deferred device address
        wr(8'h49, 32'h85);
        chk(32'({REMOTE_WAKEUP, DEV_ADDR}), 32'h85);
        wr(8'h45, 32'h01);
        wr(8'h49, 32'h12);
        chk(32'(DEV_ADDR), 32'h05);
        usb_sie_model_i.pulse(16'h4000, 3);
        chk(32'(DEV_ADDR), 32'h12);
        rc(8'h45, 32'h00);
        // bus reset empties the fifo command register
        wr(8'h4a, 32'hff);
        usb_sie_model_i.pulse(16'h8000, 0);
        chk(32'(FIFO_CMD), 32'h0);
        rc(8'h4c, 32'ha0);
        // second reset in mid-run
        @(posedge REF_CLK) NRST <= 1'b0;
        repeat (3) @(posedge REF_CLK);
        NRST <= 1'b1;
        rc(8'h44, 32'h00);
        chk(32'(EP_CFG), 32'({4'hf, 4'he, 3'h7, 3'h0}));
        results();
    end
endmodule
`default_nettype wire

// >>> sim/usb_ep_status_chk.sv
// concurrent checks on the endpoint status block ports
`timescale 1ns/1ps
`default_nettype none
`include "usb_ep_params.svh"

module usb_ep_status_chk
    import usb_ep_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic              REF_CLK,
    input wire logic              NRST,
    input wire logic              PSEL,
    input wire logic              PENABLE,
    input wire logic              PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0]       PWDATA,
    input wire logic [3:0]        PSTRB,
    input wire logic [31:0]       PRDATA,
    input wire logic              PREADY,
    input wire logic              PSLVERR,
    input wire sie_ev_s           SIE_EV,
    input wire ep_cfg_s           EP_CFG,
    input wire logic [6:0]        DEV_ADDR,
    input wire logic              REMOTE_WAKEUP,
    input wire logic [4:0]        FIFO_CMD,
    input wire logic              ACCESS_EVENT,
    input wire logic              IRQ
);
    logic [7:0] idx;
    logic       mapped;
    logic       wr_go;
    logic       addr_wr;
    logic       ev_any;
    // word decode; unaligned addresses and the holes at 42, 46, 4b and 4f answer with an error
    assign idx     = PADDR[9:2];
    assign mapped  = (PADDR >> 10) == '0 && PADDR[1:0] == 2'b00 && idx[7:4] == 4'h4
                  && !(idx[3:0] inside {4'h2, 4'h6, 4'hb, 4'hf});
    assign wr_go   = PSEL && PENABLE && PWRITE && PSTRB[0] && mapped;
    assign addr_wr = wr_go && idx == `IDX_DEV_ADDR;
    assign ev_any  = |SIE_EV;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);

    // completed low-byte register write to one index
    sequence s_wr(logic [7:0] a);
        wr_go && idx == a;
    endsequence
    ////////////////////////////////////////////////////////////
    a_err_unmapped: assert property (PSEL && PENABLE |-> PSLVERR == !mapped)
        else $error("error response disagrees with decode");
    a_rdata_upper: assert property (PSEL && PENABLE && !PWRITE |-> PRDATA[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_ep0_fixed: assert property (EP_CFG.enable[0])
        else $error("endpoint 0 disabled");
    a_enable_write: assert property (s_wr(`IDX_EP_ENABLE) |=> EP_CFG.enable[3:1] == $past(PWDATA[3:1]))
        else $error("enable write lost");
    a_dir_write: assert property (s_wr(`IDX_DIR_TOGGLE) |=> EP_CFG.dir_in == $past(PWDATA[3:1]))
        else $error("direction write lost");
    a_toggle_clear: assert property (s_wr(`IDX_DIR_TOGGLE) ##0 !PWDATA[0] |-> ##2 EP_CFG.data_toggle == 3'h0)
        else $error("toggles not forced to data0");
    a_access_int: assert property (SIE_EV.ep_access[0] && !SIE_EV.ep0_nak |=> ACCESS_EVENT)
        else $error("endpoint 0 access raised no event");
    a_bus_reset: assert property (SIE_EV.bus_reset |=> FIFO_CMD == 5'h0)
        else $error("fifo command survived bus reset");
    a_addr_cause: assert property ($changed(DEV_ADDR) |-> $past(SIE_EV.in_done) || $past(addr_wr))
        else $error("device address moved without cause");
    a_irq_cause: assert property ($rose(IRQ) |-> $past(ev_any) || $past(wr_go) || $past(ev_any, 2) || $past(wr_go, 2))
        else $error("interrupt rose without cause");
endmodule

bind usb_endpoint_status_control usb_ep_status_chk #(.ADDR_W(ADDR_W)) usb_ep_status_chk_i (
    .REF_CLK(REF_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SIE_EV(SIE_EV), .EP_CFG(EP_CFG), .DEV_ADDR(DEV_ADDR), .REMOTE_WAKEUP(REMOTE_WAKEUP),
    .FIFO_CMD(FIFO_CMD), .ACCESS_EVENT(ACCESS_EVENT), .IRQ(IRQ)
);
`default_nettype wire

// >>> sim/usb_sie_model.sv
// serial-engine stand-in: one-cycle event pulses toward the status block
`timescale 1ns/1ps
`default_nettype none

module usb_sie_model
    import usb_ep_pkg::*;
(
    input  wire logic   REF_CLK,
    output var sie_ev_s SIE_EV
);
    // quiet until asked; no event lingers past its cycle
    initial begin
        SIE_EV = '0;
    end
    ////////////////////////////////////////
    // gap idle cycles model a slow host; set and cleared just after edges
    task automatic pulse(input logic [15:0] bits, input int gap);
        repeat (gap + 1) @(posedge REF_CLK);
        SIE_EV <= sie_ev_s'(bits);
        @(posedge REF_CLK);
        SIE_EV <= '0;
        #1;
    endtask
endmodule
`default_nettype wire
